/* File: hw/rcse_engine.v */
// remote command interpreter with the 488.2 status model
`timescale 1ns/1ps
`include "rcse_regs.vh"
module rcse_engine #(
  parameter [15:0] COMPANY_ID = 16'h0a11, // arbitrary value
  parameter [15:0] MODEL_ID   = 16'h0b22, // arbitrary value
  parameter [15:0] SERIAL_ID  = 16'h0c33, // arbitrary value
  parameter [15:0] FW_DISP    = 16'h0100, // display firmware
  parameter [15:0] FW_WAVE    = 16'h0101, // waveform firmware
  parameter [15:0] FW_REM     = 16'h0102  // remote firmware
)(
  input  wire        clock_i,
  input  wire        reset_n_i,
  input  wire        unit_valid_i,        // decoded unit strobe
  input  wire [4:0]  unit_op_i,           // unit opcode
  input  wire [15:0] unit_arg_i,          // unit parameter
  input  wire        term_nl_i,           // newline seen
  input  wire        term_eoi_i,          // end-or-identify seen
  input  wire        link_serial_i,       // unit came over serial
  input  wire        page_exit_key_i,     // panel key, async pin
  input  wire        questionable_summary_bit_event_i,        // questionable event pulse
  input  wire        dev_error_i,         // device error pulse
  input  wire        selftest_fail_i,     // self-test outcome
  input  wire        resp_ready_i,        // host takes answer word
  output reg         resp_valid_o,        // answer word pending
  output reg  [15:0] resp_data_o,         // answer word
  output reg         resp_last_o,         // final word of answer
  output wire [7:0]  status_summary_byte_o,
  output wire        service_request_o,   // mss / rqs
  output reg         remote_o,            // remote state
  output wire        panel_keys_en_o,     // all panel keys live
  output wire        couple_all_o,        // voltage to all phases
  output wire [1:0]  phase_sel_o,         // selected phase 1-3
  output wire [11:0] second_phase_offset_o,
  output wire [11:0] third_phase_offset_o,
  output wire [47:0] phase_volt_o         // three 16-bit setpoints
);
  // ==================================================
  // settings vector layout
  localparam SW     = 75;  // settings width
  localparam P_OFF3 = 48;  // third phase offset
  localparam P_OFF2 = 60;  // second phase offset
  localparam P_SEL  = 72;  // phase select
  localparam P_COUP = 74;  // coupling all
  localparam [SW-1:0] DEFAULTS =
    {1'b0, `RCSE_DEF_SEL, `RCSE_DEF_OFF2, `RCSE_DEF_OFF3, 48'h0};

  reg  [SW-1:0] live_r;        // settings in effect
  reg  [SW-1:0] shd_r;         // settings incl. deferred units
  reg  [SW-1:0] live_nxt;
  reg  [SW-1:0] shd_nxt;
  reg  [7:0]    ese_r;         // standard event enable
  reg  [7:0]    ese_nxt;
  reg  [7:0]    sre_r;         // service request enable
  reg  [7:0]    sre_nxt;
  reg           questionable_summary_bit_r;        // questionable summary latch
  reg           questionable_summary_bit_nxt;
  reg  [2:0]    err_r;         // error slot, overflow folds
  reg  [2:0]    err_nxt;
  reg  [2:0]    new_err;       // error raised this cycle
  reg  [2:0]    idx_r;         // identity word index, 0 idle
  reg  [2:0]    idx_nxt;
  reg           pon_r;         // first cycle after reset
  reg           rv_nxt;
  reg  [15:0]   rd_nxt;
  reg           rl_nxt;
  reg           remote_nxt;
  reg  [7:0]    evt_set;       // event pulses to the latch
  reg           evt_clr;       // event register read
  reg           bank_wr;       // store pulse
  reg           key_s1_r;      // synchroniser stage one
  reg           key_s2_r;      // synchroniser stage two
  reg           key_d_r;       // edge detect history
  wire [7:0]    evt_q;         // latched events
  wire [SW-1:0] bank_q;        // recalled group
  wire [1:0]    bank_sel;      // group index, zero based
  wire          arg_grp_ok;    // parameter within 1-3
  wire          arg_off_ok;    // offset within range
  wire          esb;
  wire          mss;
  wire [7:0]    stb_low;       // status byte without mss
  wire          pending;       // answer still unread
  wire          key_press;     // page/exit rising edge
  integer       i;

  // ==================================================
  // status byte composition
  assign esb = |(evt_q & ese_r);
  assign stb_low = {1'b0, 1'b0, esb, resp_valid_o, questionable_summary_bit_r, 3'h0};
  // mss bit of the enable mask cannot feed itself
  assign mss = |(stb_low & sre_r & 8'hbf);
  assign status_summary_byte_o = stb_low | {1'b0, mss, 6'h00};
  assign service_request_o = mss;

  // ==================================================
  // argument checks
  assign bank_sel   = unit_arg_i[1:0] - 2'h1;
  assign arg_grp_ok = (unit_arg_i >= 16'h0001) && (unit_arg_i <= 16'h0003);
  assign arg_off_ok = (unit_arg_i <= {4'h0, `RCSE_MAX_OFF});
  assign pending    = resp_valid_o && !(resp_ready_i && resp_last_o);
  assign key_press  = key_s2_r && !key_d_r;

  // ==================================================
  // outputs taken from the live settings
  assign couple_all_o          = live_r[P_COUP];
  assign phase_sel_o           = live_r[P_SEL +: 2];
  assign second_phase_offset_o = live_r[P_OFF2 +: 12];
  assign third_phase_offset_o  = live_r[P_OFF3 +: 12];
  assign phase_volt_o          = live_r[47:0];
  // page/exit stays live even in remote state
  assign panel_keys_en_o       = !remote_o;

  // identity fields in answer order
  function [15:0] idn_word;
    input [2:0] idx;
    begin
      case (idx)
        3'h1:    idn_word = COMPANY_ID;
        3'h2:    idn_word = MODEL_ID;
        3'h3:    idn_word = SERIAL_ID;
        3'h4:    idn_word = FW_DISP;
        3'h5:    idn_word = FW_WAVE;
        default: idn_word = FW_REM;
      endcase
    end
  endfunction

  // ==================================================
  // unit execution, one unit per cycle in arrival order
  always @*
  begin
    live_nxt   = live_r;
    shd_nxt    = shd_r;
    ese_nxt    = ese_r;
    sre_nxt    = sre_r;
    questionable_summary_bit_nxt   = questionable_summary_bit_r;
    err_nxt    = err_r;
    new_err    = `RCSE_ERR_NONE;
    idx_nxt    = idx_r;
    rv_nxt     = resp_valid_o;
    rd_nxt     = resp_data_o;
    rl_nxt     = resp_last_o;
    remote_nxt = remote_o;
    evt_set    = 8'h00;
    evt_clr    = 1'b0;
    bank_wr    = 1'b0;
    evt_set[`RCSE_EV_PON] = pon_r;
    evt_set[`RCSE_EV_DDE] = dev_error_i;
    // host drains the answer word by word
    if (resp_valid_o && resp_ready_i)
    begin
      if (idx_r != 3'h0 && idx_r != `RCSE_IDN_WORDS)
      begin
        idx_nxt = idx_r + 3'h1;
        rd_nxt  = idn_word(idx_r + 3'h1);
        rl_nxt  = (idx_r + 3'h1) == `RCSE_IDN_WORDS;
      end
      else
      begin
        rv_nxt  = 1'b0;
        rl_nxt  = 1'b0;   // last flag never outlives its word
        idx_nxt = 3'h0;
      end
    end
    if (unit_valid_i)
    begin
      // a new unit throws away an unread answer
      if (pending)
      begin
        rv_nxt  = 1'b0;
        rl_nxt  = 1'b0;
        idx_nxt = 3'h0;
        evt_set[`RCSE_EV_QYE] = 1'b1;
      end
      case (unit_op_i)
        `RCSE_OP_CLS:
        begin
          questionable_summary_bit_nxt = 1'b0;
          err_nxt  = `RCSE_ERR_NONE;
        end
        `RCSE_OP_ESE:   ese_nxt = unit_arg_i[7:0];
        `RCSE_OP_ESEQ:
        begin
          rv_nxt  = 1'b1;
          rd_nxt  = {8'h00, evt_q};
          rl_nxt  = 1'b1;
          evt_clr = 1'b1;
        end
        `RCSE_OP_IDNQ:
        begin
          rv_nxt  = 1'b1;
          rd_nxt  = idn_word(3'h1);
          rl_nxt  = 1'b0;
          idx_nxt = 3'h1;
        end
        `RCSE_OP_RCL:
          if (arg_grp_ok)
          begin
            live_nxt = bank_q;
            shd_nxt  = bank_q;
          end
          else
            new_err = `RCSE_ERR_RANGE;
        `RCSE_OP_RST:
        begin
          live_nxt = DEFAULTS;
          shd_nxt  = DEFAULTS;
        end
        `RCSE_OP_SAV:
          if (arg_grp_ok)
            bank_wr = 1'b1;
          else
            new_err = `RCSE_ERR_RANGE;
        `RCSE_OP_SRE:   sre_nxt = unit_arg_i[7:0];
        `RCSE_OP_SREQ:
        begin
          rv_nxt = 1'b1;
          rd_nxt = {8'h00, sre_r};
          rl_nxt = 1'b1;
        end
        `RCSE_OP_STBQ:
        begin
          rv_nxt = 1'b1;
          rd_nxt = {8'h00, status_summary_byte_o};
          rl_nxt = 1'b1;
        end
        `RCSE_OP_TSTQ:
        begin
          rv_nxt = 1'b1;
          rd_nxt = {15'h0000, selftest_fail_i};
          rl_nxt = 1'b1;
        end
        `RCSE_OP_ERRQ:
        begin
          rv_nxt  = 1'b1;
          rd_nxt  = {13'h0000, err_r};
          rl_nxt  = 1'b1;
          err_nxt = `RCSE_ERR_NONE;
        end
        `RCSE_OP_LOC:
          if (link_serial_i)
            remote_nxt = 1'b0;
          else
            new_err = `RCSE_ERR_EXEC;
        `RCSE_OP_REM:
          if (link_serial_i)
            remote_nxt = 1'b1;
          else
            new_err = `RCSE_ERR_EXEC;
        `RCSE_OP_COUP:
        begin
          live_nxt[P_COUP] = unit_arg_i[0];
          shd_nxt[P_COUP]  = unit_arg_i[0];
        end
        `RCSE_OP_COUPQ:
        begin
          rv_nxt = 1'b1;
          rd_nxt = {15'h0000, live_r[P_COUP]};
          rl_nxt = 1'b1;
        end
        `RCSE_OP_NSEL, `RCSE_OP_SEL:
          if (arg_grp_ok)
          begin
            live_nxt[P_SEL +: 2] = unit_arg_i[1:0];
            shd_nxt[P_SEL +: 2]  = unit_arg_i[1:0];
          end
          else if (unit_op_i == `RCSE_OP_SEL)
            new_err = `RCSE_ERR_FMT;
          else
            new_err = `RCSE_ERR_RANGE;
        `RCSE_OP_NSELQ:
        begin
          rv_nxt = 1'b1;
          rd_nxt = {14'h0000, live_r[P_SEL +: 2]};
          rl_nxt = 1'b1;
        end
        // offsets and voltage are coupled: staged until the terminator
        `RCSE_OP_OFF2:
          if (arg_off_ok)
            shd_nxt[P_OFF2 +: 12] = unit_arg_i[11:0];
          else
            new_err = `RCSE_ERR_RANGE;
        `RCSE_OP_OFF2Q:
        begin
          rv_nxt = 1'b1;
          rd_nxt = {4'h0, live_r[P_OFF2 +: 12]};
          rl_nxt = 1'b1;
        end
        `RCSE_OP_OFF3:
          if (arg_off_ok)
            shd_nxt[P_OFF3 +: 12] = unit_arg_i[11:0];
          else
            new_err = `RCSE_ERR_RANGE;
        `RCSE_OP_OFF3Q:
        begin
          rv_nxt = 1'b1;
          rd_nxt = {4'h0, live_r[P_OFF3 +: 12]};
          rl_nxt = 1'b1;
        end
        `RCSE_OP_VOLT:
          for (i = 0; i < 3; i = i + 1)
            if (shd_r[P_COUP] || (shd_r[P_SEL +: 2] == i[1:0] + 2'h1))
              shd_nxt[i*16 +: 16] = unit_arg_i;
        default:
          evt_set[`RCSE_EV_CME] = 1'b1;
      endcase
    end
    // record the error; a second one before reading folds to overflow
    if (new_err != `RCSE_ERR_NONE)
    begin
      err_nxt = (err_nxt == `RCSE_ERR_NONE) ? new_err : `RCSE_ERR_MANY;
      if (new_err == `RCSE_ERR_FMT)
        evt_set[`RCSE_EV_CME] = 1'b1;
      else
        evt_set[`RCSE_EV_EXE] = 1'b1;
    end
    // a late questionable event wins over the clear
    if (questionable_summary_bit_event_i)
      questionable_summary_bit_nxt = 1'b1;
    // terminator commits every staged coupled setting at once
    if (term_nl_i || term_eoi_i)
    begin
      live_nxt = shd_nxt;
      evt_set[`RCSE_EV_OPC] = 1'b1;
    end
    // page/exit always returns the panel to local
    if (key_press)
      remote_nxt = 1'b0;
  end

  // ==================================================
  // state registers
  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      live_r       <= DEFAULTS;
      shd_r        <= DEFAULTS;
      ese_r        <= 8'h00;
      sre_r        <= 8'h00;
      questionable_summary_bit_r       <= 1'b0;
      err_r        <= `RCSE_ERR_NONE;
      idx_r        <= 3'h0;
      pon_r        <= 1'b1;
      resp_valid_o <= 1'b0;
      resp_data_o  <= 16'h0000;
      resp_last_o  <= 1'b0;
      remote_o     <= 1'b0;
    end
    else
    begin
      live_r       <= live_nxt;
      shd_r        <= shd_nxt;
      ese_r        <= ese_nxt;
      sre_r        <= sre_nxt;
      questionable_summary_bit_r       <= questionable_summary_bit_nxt;
      err_r        <= err_nxt;
      idx_r        <= idx_nxt;
      pon_r        <= 1'b0;
      resp_valid_o <= rv_nxt;
      resp_data_o  <= rd_nxt;
      resp_last_o  <= rl_nxt;
      remote_o     <= remote_nxt;
    end
  end

  // ==================================================
  // page/exit key synchroniser, stage one read only by stage two
  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      key_s1_r <= 1'b0;
      key_s2_r <= 1'b0;
      key_d_r  <= 1'b0;
    end
    else
    begin
      key_s1_r <= page_exit_key_i;
      key_s2_r <= key_s1_r;
      key_d_r  <= key_s2_r;
    end
  end

  // ==================================================
  // event latch and save groups
  rcse_event_latch #(
    .WIDTH (8)
  ) u_events (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .set_i     (evt_set),
    .clr_i     (evt_clr),
    .q_o       (evt_q)
  );

  rcse_save_bank #(
    .WIDTH (SW),
    .DEPTH (`RCSE_GROUPS),
    .INIT  (DEFAULTS)
  ) u_bank (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .wr_i      (bank_wr),
    .sel_i     (bank_sel),
    .data_i    (live_r),
    .q_o       (bank_q)
  );
endmodule // rcse_engine

/* File: hw/rcse_regs.vh */
// constants for the remote command status engine
`ifndef RCSE_REGS_VH
`define RCSE_REGS_VH
// ==================================================
// decoded message unit opcodes
`define RCSE_OP_CLS    5'h00
`define RCSE_OP_ESE    5'h01
`define RCSE_OP_ESEQ   5'h02
`define RCSE_OP_IDNQ   5'h03
`define RCSE_OP_RCL    5'h04
`define RCSE_OP_RST    5'h05
`define RCSE_OP_SAV    5'h06
`define RCSE_OP_SRE    5'h07
`define RCSE_OP_SREQ   5'h08
`define RCSE_OP_STBQ   5'h09
`define RCSE_OP_TSTQ   5'h0a
`define RCSE_OP_ERRQ   5'h0b
`define RCSE_OP_LOC    5'h0c
`define RCSE_OP_REM    5'h0d
`define RCSE_OP_COUP   5'h0e
`define RCSE_OP_COUPQ  5'h0f
`define RCSE_OP_NSEL   5'h10
`define RCSE_OP_NSELQ  5'h11
`define RCSE_OP_SEL    5'h12
`define RCSE_OP_OFF2   5'h13
`define RCSE_OP_OFF2Q  5'h14
`define RCSE_OP_OFF3   5'h15
`define RCSE_OP_OFF3Q  5'h16
`define RCSE_OP_VOLT   5'h17
// ==================================================
// standard event bit positions
`define RCSE_EV_PON 7
`define RCSE_EV_CME 5
`define RCSE_EV_EXE 4
`define RCSE_EV_DDE 3
`define RCSE_EV_QYE 2
`define RCSE_EV_OPC 0
// ==================================================
// status byte bit positions
`define RCSE_SB_MSS 6
`define RCSE_SB_ESB 5
`define RCSE_SB_MAV 4
`define RCSE_SB_QUS 3
// ==================================================
// error codes returned by the error query
`define RCSE_ERR_NONE  3'h0
`define RCSE_ERR_FMT   3'h1
`define RCSE_ERR_RANGE 3'h2
`define RCSE_ERR_MANY  3'h3
`define RCSE_ERR_EXEC  3'h4
// ==================================================
// setting defaults and limits, offsets in tenths of a degree
`define RCSE_DEF_OFF2  12'h4b0
`define RCSE_DEF_OFF3  12'h960
`define RCSE_MAX_OFF   12'he0f
`define RCSE_DEF_SEL   2'h1
`define RCSE_GROUPS    3
`define RCSE_IDN_WORDS 3'h6
`endif

/* File: hw/rcse_event_latch.v */
// sticky standard event bits with read-to-clear
`timescale 1ns/1ps
module rcse_event_latch #(
  parameter WIDTH = 8 // number of event bits
)(
  input  wire             clock_i,
  input  wire             reset_n_i,
  input  wire [WIDTH-1:0] set_i,     // one-cycle event pulses
  input  wire             clr_i,     // read of the register
  output wire [WIDTH-1:0] q_o        // latched events
);
  // ==================================================
  // per-bit latch
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : bit_g
      reg bit_r; // latched event
      // set wins over the read clear so no event is lost
      always @(posedge clock_i)
      begin
        if (!reset_n_i)
          bit_r <= 1'b0;
        else if (set_i[g])
          bit_r <= 1'b1;
        else if (clr_i)
          bit_r <= 1'b0;
      end
      assign q_o[g] = bit_r;
    end
  endgenerate
endmodule // rcse_event_latch

/* File: hw/rcse_save_bank.v */
// numbered save/recall groups of the settings vector
`timescale 1ns/1ps
module rcse_save_bank #(
  parameter         WIDTH = 75,     // settings vector width
  parameter         DEPTH = 3,      // number of groups
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}} // content after reset
)(
  input  wire             clock_i,
  input  wire             reset_n_i,
  input  wire             wr_i,      // store pulse
  input  wire [1:0]       sel_i,     // group index, zero based
  input  wire [WIDTH-1:0] data_i,    // settings to store
  output wire [WIDTH-1:0] q_o        // settings of the group
);
  wire [WIDTH-1:0] slot_q [0:DEPTH-1]; // per-group content
  // ==================================================
  // one flop slot per group
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : slot_g
      reg [WIDTH-1:0] slot_r; // stored settings
      // write only the addressed slot
      always @(posedge clock_i)
      begin
        if (!reset_n_i)
          slot_r <= INIT;
        else if (wr_i && (sel_i == g))
          slot_r <= data_i;
      end
      assign slot_q[g] = slot_r;
    end
  endgenerate
  // caller writes and uses q_o only while sel_i is below DEPTH
  assign q_o = slot_q[sel_i];
endmodule // rcse_save_bank

/* File: testbench/rcse_engine_assertions.sv */
// port-level checker of the remote command status engine
`timescale 1ns/1ps
`include "rcse_regs.vh"
module rcse_engine_assertions (
  input wire        clock_i,
  input wire        reset_n_i,
  input wire        unit_valid_i,
  input wire [4:0]  unit_op_i,
  input wire [15:0] unit_arg_i,
  input wire        term_nl_i,
  input wire        term_eoi_i,
  input wire        resp_ready_i,
  input wire        resp_valid_o,
  input wire [15:0] resp_data_o,
  input wire        resp_last_o,
  input wire [7:0]  status_summary_byte_o,
  input wire        service_request_o,
  input wire        remote_o,
  input wire        panel_keys_en_o,
  input wire [1:0]  phase_sel_o,
  input wire [11:0] second_phase_offset_o,
  input wire [11:0] third_phase_offset_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // ==================================================
  // status byte and answer port
  chk_mav_mirror: assert property (status_summary_byte_o[4] == resp_valid_o)
    else $error("mav differs from answer pending");
  chk_unused_low: assert property ({status_summary_byte_o[7], status_summary_byte_o[2:0]} == 4'h0)
    else $error("unused status bits set");
  chk_mss_srq: assert property (service_request_o == status_summary_byte_o[6])
    else $error("service request and mss disagree");
  chk_query_answer: assert property (unit_valid_i && unit_op_i == `RCSE_OP_STBQ |=> resp_valid_o)
    else $error("status query gave no answer");
  chk_word_holds: assert property (resp_valid_o && !resp_ready_i && !unit_valid_i
    |=> resp_valid_o && $stable(resp_data_o))
    else $error("answer word moved before take");
  chk_last_valid: assert property (resp_last_o |-> resp_valid_o)
    else $error("last flag without answer");
  // ==================================================
  // panel and settings
  chk_keys_local: assert property (panel_keys_en_o == !remote_o)
    else $error("panel keys disagree with remote");
  chk_sel_applies: assert property (unit_valid_i && unit_op_i == `RCSE_OP_NSEL
    && unit_arg_i >= 16'h0001 && unit_arg_i <= 16'h0003
    |=> phase_sel_o == $past(unit_arg_i[1:0]))
    else $error("phase select not applied");
  chk_offset_held: assert property (unit_valid_i && unit_op_i == `RCSE_OP_OFF2
    && !term_nl_i && !term_eoi_i |=> $stable(second_phase_offset_o))
    else $error("coupled offset applied early");
  chk_offset_commit: assert property (unit_valid_i && unit_op_i == `RCSE_OP_OFF2
    && unit_arg_i <= 16'h0e0f && term_nl_i
    |=> second_phase_offset_o == $past(unit_arg_i[11:0]))
    else $error("offset not committed at newline");
  chk_reset_defaults: assert property ($rose(reset_n_i) |-> phase_sel_o == 2'h1
    && second_phase_offset_o == 12'h4b0 && third_phase_offset_o == 12'h960)
    else $error("settings not at defaults after reset");
  // main scenarios
  cover property (resp_valid_o && resp_ready_i && resp_last_o);
  cover property (remote_o);
  cover property (service_request_o);
endmodule // rcse_engine_assertions

/* File: testbench/rcse_host_model.sv */
// host controller that takes answer words, promptly or stalled
`timescale 1ns/1ps
module rcse_host_model (
  input  wire        clock_i,
  input  wire        stall_i,      // hold off taking words
  input  wire        resp_valid_i,
  input  wire [15:0] resp_data_i,
  input  wire        resp_last_i,
  output reg         resp_ready_o
);
  integer     n = 0;          // words taken so far
  reg  [15:0] w [0:255];      // every word taken
  reg         last [0:255];   // last flag of each word
  initial resp_ready_o = 1'b0;
  // take at the handshake edge; ready only moves just after an edge
  always @(posedge clock_i)
  begin
    if (resp_valid_i && resp_ready_o)
    begin
      w[n] = resp_data_i;
      last[n] = resp_last_i;
      n = n + 1;
    end
    resp_ready_o <= #1 !stall_i;
  end
endmodule // rcse_host_model

/* File: testbench/rcse_engine_bench.sv */
// self-checking bench of the remote command status engine
`timescale 1ns/1ps
`include "rcse_regs.vh"
module rcse_engine_bench;
  reg         clock_i = 1'b0;   // 100 MHz
  reg         reset_n_i = 1'b0;
  reg         uv = 1'b0, nl = 1'b0, eoi = 1'b0, ser = 1'b0, key = 1'b0;
  reg         qe = 1'b0, de = 1'b0, stf = 1'b1, stall = 1'b0;
  reg  [4:0]  op = 5'h00;
  reg  [15:0] arg = 16'h0000;
  reg  [95:0] idv = 96'h0a11_0b22_0c33_0100_0101_0102; // design defaults
  wire        rv, rdy, rl, srq, rem, keys, ca;
  wire [15:0] rd;
  wire [7:0]  stb;
  wire [1:0]  sel;
  wire [11:0] o2, o3;
  wire [47:0] pv;
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     c;
  always #5 clock_i = ~clock_i;
  rcse_engine DUT (.clock_i(clock_i), .reset_n_i(reset_n_i), .unit_valid_i(uv),
    .unit_op_i(op), .unit_arg_i(arg), .term_nl_i(nl), .term_eoi_i(eoi),
    .link_serial_i(ser), .page_exit_key_i(key), .questionable_summary_bit_event_i(qe), .dev_error_i(de),
    .selftest_fail_i(stf), .resp_ready_i(rdy), .resp_valid_o(rv), .resp_data_o(rd),
    .resp_last_o(rl), .status_summary_byte_o(stb), .service_request_o(srq),
    .remote_o(rem), .panel_keys_en_o(keys), .couple_all_o(ca), .phase_sel_o(sel),
    .second_phase_offset_o(o2), .third_phase_offset_o(o3), .phase_volt_o(pv));
  rcse_host_model H (.clock_i(clock_i), .stall_i(stall), .resp_valid_i(rv),
    .resp_data_i(rd), .resp_last_i(rl), .resp_ready_o(rdy));
  // ==================================================
  // shared helpers
  task close_out;
  begin
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task cmp(input logic [63:0] g, input logic [63:0] e);
  begin
    check_count = check_count + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  end
  endtask
  task tick;
  begin
    @(posedge clock_i);
    #1;
  end
  endtask
  // one unit, then one edge so its effect has landed
  task u(input [4:0] o, input [15:0] a, input [1:0] t);
  begin
    uv = 1'b1;
    op = o;
    arg = a;
    {eoi, nl} = t;
    tick;
    uv = 1'b0;
    {eoi, nl} = 2'b00;
    tick;
  end
  endtask
  // bounded wait on the host's word count
  task wait_n(input integer k);
    integer i;
  begin
    for (i = 0; i < 40 && H.n < k; i = i + 1)
      tick;
    if (H.n < k)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: answer missing", $time);
      close_out;
    end
  end
  endtask
  task q(input [4:0] o, input [15:0] m, input [15:0] e);
  begin
    c = H.n;
    u(o, 16'h0000, 2'b00);
    wait_n(c + 1);
    cmp(H.w[c] & m, e);
  end
  endtask
  // ==================================================
  // scenarios
  task t_start;
  begin
    cmp({sel, o2, o3}, {2'h1, 12'h4b0, 12'h960});
    q(`RCSE_OP_ESEQ, 16'h00ff, 16'h0080);
    q(`RCSE_OP_ESEQ, 16'h00ff, 16'h0000);
    // unknown opcode raises only the command error event
    u(5'h1f, 16'h0000, 2'b00);
    q(`RCSE_OP_ESEQ, 16'h00ff, 16'h0020);
    q(`RCSE_OP_TSTQ, 16'hffff, 16'h0001);
    $display("start test done");
  end
  endtask
  task t_status;
  begin
    u(`RCSE_OP_ESE, 16'h0008, 2'b00);
    u(`RCSE_OP_SRE, 16'h0020, 2'b00);
    cmp({srq, stb[5]}, 2'b00);
    de = 1'b1;
    tick;
    de = 1'b0;
    tick;
    cmp({srq, stb[6:5]}, 3'b111);
    q(`RCSE_OP_STBQ, 16'h00ef, 16'h0060);
    q(`RCSE_OP_SREQ, 16'h00ff, 16'h0020);
    q(`RCSE_OP_ESEQ, 16'h0008, 16'h0008);
    cmp({srq, stb[5]}, 2'b00);
    $display("status test done");
  end
  endtask
  task t_errors;
  begin
    u(`RCSE_OP_NSEL, 16'h0004, 2'b00);
    q(`RCSE_OP_ERRQ, 16'hffff, 16'h0002);
    u(`RCSE_OP_SEL, 16'h0007, 2'b00);
    q(`RCSE_OP_ERRQ, 16'hffff, 16'h0001);
    u(`RCSE_OP_SAV, 16'h0000, 2'b00);
    u(`RCSE_OP_OFF3, 16'h0e10, 2'b01);
    q(`RCSE_OP_ERRQ, 16'hffff, 16'h0003);
    u(`RCSE_OP_REM, 16'h0000, 2'b00);
    q(`RCSE_OP_ERRQ, 16'hffff, 16'h0004);
    cmp({rem, o3}, {1'b0, 12'h960});
    qe = 1'b1;
    tick;
    qe = 1'b0;
    u(`RCSE_OP_RCL, 16'h0004, 2'b00);
    cmp(stb[3], 1'b1);
    u(`RCSE_OP_CLS, 16'h0000, 2'b00);
    cmp(stb[3], 1'b0);
    q(`RCSE_OP_ERRQ, 16'hffff, 16'h0000);
    $display("error test done");
  end
  endtask
  task t_settings;
  begin
    u(`RCSE_OP_NSEL, 16'h0002, 2'b00);
    u(`RCSE_OP_SAV, 16'h0002, 2'b00);
    u(`RCSE_OP_NSEL, 16'h0003, 2'b00);
    q(`RCSE_OP_NSELQ, 16'hffff, 16'h0003);
    u(`RCSE_OP_RCL, 16'h0002, 2'b00);
    cmp(sel, 2'h2);
    u(`RCSE_OP_OFF2, 16'h0384, 2'b00);
    cmp(o2, 12'h4b0);
    nl = 1'b1;
    tick;
    nl = 1'b0;
    tick;
    cmp(o2, 12'h384);
    q(`RCSE_OP_OFF2Q, 16'hffff, 16'h0384);
    u(`RCSE_OP_OFF3, 16'h012c, 2'b10);
    q(`RCSE_OP_OFF3Q, 16'hffff, 16'h012c);
    u(`RCSE_OP_RST, 16'h0000, 2'b00);
    // host pause after reset, scaled down to keep the run short
    repeat (8) tick;
    cmp({sel, o2, o3}, {2'h1, 12'h4b0, 12'h960});
    $display("settings test done");
  end
  endtask
  task t_volt;
  begin
    u(`RCSE_OP_COUP, 16'h0001, 2'b00);
    q(`RCSE_OP_COUPQ, 16'hffff, 16'h0001);
    u(`RCSE_OP_VOLT, 16'h0123, 2'b11);
    cmp(pv, {3{16'h0123}});
    u(`RCSE_OP_COUP, 16'h0000, 2'b00);
    u(`RCSE_OP_SEL, 16'h0002, 2'b00);
    u(`RCSE_OP_VOLT, 16'h0456, 2'b01);
    cmp({ca, sel, pv}, {3'b010, 16'h0123, 16'h0456, 16'h0123});
    $display("voltage test done");
  end
  endtask
  task t_panel;
  begin
    ser = 1'b1;
    u(`RCSE_OP_REM, 16'h0000, 2'b00);
    cmp({rem, keys}, 2'b10);
    u(`RCSE_OP_LOC, 16'h0000, 2'b00);
    cmp({rem, keys}, 2'b01);
    u(`RCSE_OP_REM, 16'h0000, 2'b00);
    key = 1'b1;
    repeat (4) tick;
    key = 1'b0;
    cmp({rem, keys}, 2'b01);
    ser = 1'b0;
    $display("panel test done");
  end
  endtask
  task t_answers;
    integer i;
  begin
    stall = 1'b1;
    c = H.n;
    u(`RCSE_OP_STBQ, 16'h0000, 2'b00);
    u(`RCSE_OP_STBQ, 16'h0000, 2'b00);
    stall = 1'b0;
    wait_n(c + 1);
    q(`RCSE_OP_ESEQ, 16'h0004, 16'h0004);
    stall = 1'b1;
    c = H.n;
    u(`RCSE_OP_IDNQ, 16'h0000, 2'b00);
    repeat (3) tick;
    stall = 1'b0;
    wait_n(c + 6);
    for (i = 0; i < 6; i = i + 1)
      cmp({H.last[c + i], H.w[c + i]}, {(i == 5), idv[95 - 16 * i -: 16]});
    $display("answer test done");
  end
  endtask
  // ==================================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge clock_i);
    #1;
    reset_n_i = 1'b1;
    // power-on event lands one edge after release
    tick;
    t_start;
    t_status;
    t_errors;
    t_settings;
    t_volt;
    t_panel;
    t_answers;
    close_out;
  end
endmodule // rcse_engine_bench
bind rcse_engine rcse_engine_assertions A (.*);
